// [core/i2c_flag_regs.vh]
`ifndef I2C_FLAG_REGS_VH
`define I2C_FLAG_REGS_VH

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FLAG_RESET_VAL      1'b0
`define SHIFT_RESET_VAL     8'h00
`define BITCNT_RESET_VAL    4'h0

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define FRAME_BITS          4'h8
`define ADDR_MSB            7
`define ADDR_LSB            1
`define DIR_POS             0
`define GENERAL_CALL_ADDR   7'h00
`define DIR_WRITE           1'b0

`endif

// [core/pin_sync_edge.v]
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Two-stage synchroniser with edge detection
// ----------------------------------------------------------------
module pin_sync_edge (
	input  wire i_clk,
	input  wire i_rst_n,
	input  wire i_pin,
	output reg  o_level,
	output wire o_rise,
	output wire o_fall
);

	reg meta_q;
	reg prev_q;

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q  <= 1'b1;
			o_level <= 1'b1;
			prev_q  <= 1'b1;
		end else begin
			meta_q  <= i_pin;
			o_level <= meta_q;
			prev_q  <= o_level;
		end
	end

	assign o_rise = o_level & ~prev_q;
	assign o_fall = ~o_level & prev_q;

endmodule

// [core/i2c_status_flag_logic.v]
`timescale 1ns/100ps
`include "i2c_flag_regs.vh"

// How it works
// - Master transmit, bus format: driven SDA differs from pin at SCL rise sets arb flag.
// - Master mode, bus format: driving SDA high while a start is seen sets arb flag.
// - Clocked sync: final bit received while receive-full is 1 sets overrun.
// - Arb/overrun flag clears only on write 0 after reading it as 1.
// - Slave receive: first frame after start matching own address sets flag.
// - Slave receive: general call also sets own-address flag.
// - Own-address flag clears on write 0 after reading it as 1.
// - General-call flag set only in slave receive, bus format, on general call.
// - General-call flag clears on write 0 after reading it as 1.
module i2c_status_flag_logic (
	input  wire       i_clk,
	input  wire       i_rst_n,
	input  wire       i_scl,
	input  wire       i_sda,
	input  wire       i_sda_drive,
	input  wire       i_master,
	input  wire       i_transmit,
	input  wire       i_bus_format,
	input  wire       i_receive_data_full_flag,
	input  wire       i_sync_last_bit,
	input  wire [6:0] i_own_slave_address_field,
	input  wire       i_flag_read,
	input  wire       i_flag_write,
	input  wire       i_wr_arb_lost_or_overrun,
	input  wire       i_wr_own_address_match,
	input  wire       i_wr_general_call_match,
	output reg        o_arb_lost_or_overrun_flag,
	output reg        o_own_address_match_flag,
	output reg        o_general_call_match_flag
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	wire scl_level;
	wire scl_rise;
	wire sda_level;
	wire sda_rise;
	wire sda_fall;

	pin_sync_edge scl_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_pin   (i_scl),
		.o_level (scl_level),
		.o_rise  (scl_rise),
		.o_fall  ()
	);

	pin_sync_edge sda_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_pin   (i_sda),
		.o_level (sda_level),
		.o_rise  (sda_rise),
		.o_fall  (sda_fall)
	);

	// Equal sync depth on both pins keeps start and stop aligned
	wire start_det = sda_fall & scl_level;
	wire stop_det  = sda_rise & scl_level;

	// ------------------------------------------------------------
	// Clear sequence: write 0 after a read that returned 1
	// ------------------------------------------------------------
	function clear_hit;
		input armed;
		input wr;
		input wdata;
		begin
			clear_hit = armed & wr & ~wdata;
		end
	endfunction

	function next_flag;
		input cur;
		input set;
		input clr;
		begin
			// Set beats a simultaneous clear; writing 1 does nothing
			if (set)
				next_flag = 1'b1;
			else if (clr)
				next_flag = 1'b0;
			else
				next_flag = cur;
		end
	endfunction

	function next_arm;
		input cur;
		input flag;
		input rd;
		input wr;
		begin
			if (rd)
				next_arm = flag;
			else if (wr)
				next_arm = 1'b0;
			else
				next_arm = cur;
		end
	endfunction

	// ------------------------------------------------------------
	// First-frame capture after a start
	// ------------------------------------------------------------
	reg [7:0] shift_q;
	reg [3:0] bitcnt_q;
	reg       first_frame_q;

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			shift_q       <= `SHIFT_RESET_VAL;
			bitcnt_q      <= `BITCNT_RESET_VAL;
			first_frame_q <= 1'b0;
		end else if (start_det) begin
			shift_q       <= `SHIFT_RESET_VAL;
			bitcnt_q      <= `BITCNT_RESET_VAL;
			first_frame_q <= 1'b1;
		end else if (stop_det) begin
			first_frame_q <= 1'b0;
		end else if (first_frame_q && scl_rise) begin
			shift_q  <= {shift_q[6:0], sda_level};
			bitcnt_q <= bitcnt_q + 4'h1;
			if (bitcnt_q == `FRAME_BITS - 4'h1)
				first_frame_q <= 1'b0;
		end
	end

	wire frame_done = first_frame_q & scl_rise &
		(bitcnt_q == `FRAME_BITS - 4'h1);
	// Bit 0 is read straight off the synchroniser at the eighth rise
	wire [7:0] frame = {shift_q[6:0], sda_level};
	wire slave_rx = ~i_master & ~i_transmit;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	wire gc_addr = (frame[`ADDR_MSB:`ADDR_LSB] == `GENERAL_CALL_ADDR) &
		(frame[`DIR_POS] == `DIR_WRITE);
	wire own_addr = frame[`ADDR_MSB:`ADDR_LSB] ==
		i_own_slave_address_field;

	// ------------------------------------------------------------
	// Set conditions
	// ------------------------------------------------------------
	wire set_arb_data = i_master & i_transmit & i_bus_format &
		scl_rise & (i_sda_drive != sda_level);
	wire set_arb_start = i_master & i_bus_format & start_det &
		i_sda_drive;
	wire set_overrun = ~i_bus_format & i_sync_last_bit &
		i_receive_data_full_flag;
	wire set_arb = set_arb_data | set_arb_start | set_overrun;
	wire set_own = frame_done & slave_rx &
		(own_addr | gc_addr);
	wire set_gc = frame_done & slave_rx & i_bus_format &
		gc_addr;

	// ------------------------------------------------------------
	// Flags and read arming
	// ------------------------------------------------------------
	reg arm_arb_q;
	reg arm_own_q;
	reg arm_gc_q;

	wire clr_arb = clear_hit(arm_arb_q, i_flag_write,
		i_wr_arb_lost_or_overrun);
	wire clr_own = clear_hit(arm_own_q, i_flag_write,
		i_wr_own_address_match);
	wire clr_gc = clear_hit(arm_gc_q, i_flag_write,
		i_wr_general_call_match);

	// ------------------------------------------------------------
	// Next flag and arm values
	// ------------------------------------------------------------
	reg arb_d;
	reg own_d;
	reg gc_d;
	reg arm_arb_d;
	reg arm_own_d;
	reg arm_gc_d;

	always @* begin
		arb_d     = next_flag(o_arb_lost_or_overrun_flag, set_arb,
			clr_arb);
		own_d     = next_flag(o_own_address_match_flag, set_own,
			clr_own);
		gc_d      = next_flag(o_general_call_match_flag, set_gc,
			clr_gc);
		// A read arms the clear only for a flag it saw as 1
		arm_arb_d = next_arm(arm_arb_q, o_arb_lost_or_overrun_flag,
			i_flag_read, i_flag_write);
		arm_own_d = next_arm(arm_own_q, o_own_address_match_flag,
			i_flag_read, i_flag_write);
		arm_gc_d  = next_arm(arm_gc_q, o_general_call_match_flag,
			i_flag_read, i_flag_write);
	end

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_arb_lost_or_overrun_flag <= `FLAG_RESET_VAL;
			o_own_address_match_flag   <= `FLAG_RESET_VAL;
			o_general_call_match_flag  <= `FLAG_RESET_VAL;
			arm_arb_q                  <= 1'b0;
			arm_own_q                  <= 1'b0;
			arm_gc_q                   <= 1'b0;
		end else begin
			o_arb_lost_or_overrun_flag <= arb_d;
			o_own_address_match_flag   <= own_d;
			o_general_call_match_flag  <= gc_d;
			arm_arb_q                  <= arm_arb_d;
			arm_own_q                  <= arm_own_d;
			arm_gc_q                   <= arm_gc_d;
		end
	end

endmodule

// [sim/bus_partner.sv]
`timescale 1ns/100ps
// ----
// Other bus party: start, frame, stop
// ----
module bus_partner (
	output logic o_scl,
	output logic o_sda
);
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic frame(input logic [7:0] b);
		#30 o_sda = 1'b0;
		#400 o_scl = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			o_sda = b[i];
			#200 o_scl = 1'b1;
			#400 o_scl = 1'b0;
			#200;
		end
		o_sda = 1'b0;
		#200 o_scl = 1'b1;
		#200 o_sda = 1'b1;
		#400;
	endtask
endmodule

// [sim/flag_checker_assertions.sv]
`timescale 1ns/100ps
module flag_checker (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_master,
	input wire i_transmit,
	input wire i_bus_format,
	input wire i_receive_data_full_flag,
	input wire i_sync_last_bit,
	input wire i_flag_read,
	input wire i_flag_write,
	input wire i_wr_arb_lost_or_overrun,
	input wire i_wr_own_address_match,
	input wire o_arb_lost_or_overrun_flag,
	input wire o_own_address_match_flag,
	input wire o_general_call_match_flag
);
	wire arb = o_arb_lost_or_overrun_flag;
	wire own = o_own_address_match_flag;
	wire gc = o_general_call_match_flag;
	wire wr = i_flag_write;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	ovr_set_a: assert property (
		!i_bus_format && i_sync_last_bit && i_receive_data_full_flag |=> arb)
		else $error("overrun missed");
	arb_sticky_a: assert property (arb && !wr |=> arb)
		else $error("arb flag dropped");
	own_sticky_a: assert property (own && !wr |=> own)
		else $error("own flag dropped");
	gc_sticky_a: assert property (gc && !wr |=> gc)
		else $error("gc flag dropped");
	write_one_a: assert property (
		wr && i_wr_own_address_match && own |=> own)
		else $error("write 1 cleared own");
	arb_clear_a: assert property (
		arb && i_flag_read && !i_bus_format ##1 wr && !i_flag_read &&
		!i_wr_arb_lost_or_overrun && !i_sync_last_bit |=> !arb)
		else $error("arb clear failed");
	gc_mode_a: assert property (
		$rose(gc) |-> !$past(i_master) && !$past(i_transmit) &&
		$past(i_bus_format))
		else $error("gc set out of mode");
	own_mode_a: assert property (
		$rose(own) |-> !$past(i_master) && !$past(i_transmit))
		else $error("own set out of mode");
	cover property ($rose(arb));
	cover property ($rose(gc));
	cover property (own && wr);
endmodule
bind i2c_status_flag_logic flag_checker chk (
	.i_clk                      (i_clk),
	.i_rst_n                    (i_rst_n),
	.i_master                   (i_master),
	.i_transmit                 (i_transmit),
	.i_bus_format               (i_bus_format),
	.i_receive_data_full_flag   (i_receive_data_full_flag),
	.i_sync_last_bit            (i_sync_last_bit),
	.i_flag_read                (i_flag_read),
	.i_flag_write               (i_flag_write),
	.i_wr_arb_lost_or_overrun   (i_wr_arb_lost_or_overrun),
	.i_wr_own_address_match     (i_wr_own_address_match),
	.o_arb_lost_or_overrun_flag (o_arb_lost_or_overrun_flag),
	.o_own_address_match_flag   (o_own_address_match_flag),
	.o_general_call_match_flag  (o_general_call_match_flag)
);

// [sim/tb.sv]
`timescale 1ns/100ps
module tb;
	logic i_clk, i_rst_n, i_sda_drive, i_master, i_transmit, i_bus_format;
	logic i_receive_data_full_flag, i_sync_last_bit, i_flag_read;
	logic i_flag_write, i_wr_arb_lost_or_overrun, i_wr_own_address_match;
	logic i_wr_general_call_match, o_arb_lost_or_overrun_flag;
	logic o_own_address_match_flag, o_general_call_match_flag;
	logic [6:0] i_own_slave_address_field;
	wire i_scl, line;
	wire i_sda = line & i_sda_drive;
	wire [2:0] f = {o_arb_lost_or_overrun_flag, o_own_address_match_flag,
		o_general_call_match_flag};
	int num_errors, n_tests;
	bus_partner bus (.o_scl(i_scl), .o_sda(line));
	i2c_status_flag_logic dut (
		.i_clk                      (i_clk),
		.i_rst_n                    (i_rst_n),
		.i_scl                      (i_scl),
		.i_sda                      (i_sda),
		.i_sda_drive                (i_sda_drive),
		.i_master                   (i_master),
		.i_transmit                 (i_transmit),
		.i_bus_format               (i_bus_format),
		.i_receive_data_full_flag   (i_receive_data_full_flag),
		.i_sync_last_bit            (i_sync_last_bit),
		.i_own_slave_address_field  (i_own_slave_address_field),
		.i_flag_read                (i_flag_read),
		.i_flag_write               (i_flag_write),
		.i_wr_arb_lost_or_overrun   (i_wr_arb_lost_or_overrun),
		.i_wr_own_address_match     (i_wr_own_address_match),
		.i_wr_general_call_match    (i_wr_general_call_match),
		.o_arb_lost_or_overrun_flag (o_arb_lost_or_overrun_flag),
		.o_own_address_match_flag   (o_own_address_match_flag),
		.o_general_call_match_flag  (o_general_call_match_flag)
	);
	// ----
	// Clock, checks, software access
	// ----
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	task automatic chk(input string n, input logic [2:0] s, e);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %s expected %b seen %b", n, e, s);
		end
	endtask
	task automatic sw(input logic rd, input logic [2:0] d);
		@(posedge i_clk);
		i_flag_read <= rd;
		@(posedge i_clk);
		i_flag_read <= 1'b0;
		i_flag_write <= 1'b1;
		{i_wr_arb_lost_or_overrun, i_wr_own_address_match,
			i_wr_general_call_match} <= d;
		@(posedge i_clk);
		i_flag_write <= 1'b0;
		#1;
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_own;
		bus.frame(8'h55);
		chk("own", f, 3'b010);
		sw(1'b0, 3'b000);
		chk("own nord", f, 3'b010);
		sw(1'b1, 3'b111);
		chk("own w1", f, 3'b010);
		sw(1'b1, 3'b000);
		chk("own clr", f, 3'b000);
		bus.frame(8'h56);
		chk("own miss", f, 3'b000);
		@(posedge i_clk) i_own_slave_address_field <= 7'h55;
		bus.frame(8'haa);
		chk("own moved", f, 3'b010);
		sw(1'b1, 3'b000);
		chk("own clr2", f, 3'b000);
		$display("own done");
	endtask
	task automatic t_gc;
		bus.frame(8'h00);
		chk("gc", f, 3'b011);
		sw(1'b1, 3'b010);
		chk("gc clr", f, 3'b010);
		sw(1'b1, 3'b000);
		bus.frame(8'h01);
		chk("gc read", f, 3'b000);
		@(posedge i_clk) i_bus_format <= 1'b0;
		bus.frame(8'h00);
		chk("gc sync", f, 3'b010);
		sw(1'b1, 3'b000);
		$display("gc done");
	endtask
	task automatic t_arb;
		@(posedge i_clk);
		i_bus_format <= 1'b1;
		i_master <= 1'b1;
		i_transmit <= 1'b1;
		i_sda_drive <= 1'b0;
		fork
			bus.frame(8'h00);
			begin
				repeat (8) @(posedge i_clk);
				i_sda_drive <= 1'b1;
			end
		join
		chk("arb", f, 3'b100);
		sw(1'b0, 3'b000);
		chk("arb nord", f, 3'b100);
		sw(1'b1, 3'b000);
		@(posedge i_clk) i_transmit <= 1'b0;
		bus.frame(8'hff);
		chk("start", f, 3'b100);
		sw(1'b1, 3'b000);
		chk("arb clr", f, 3'b000);
		$display("arb done");
	endtask
	task automatic t_ovr;
		@(posedge i_clk);
		i_master <= 1'b0;
		i_bus_format <= 1'b0;
		i_sync_last_bit <= 1'b1;
		@(posedge i_clk);
		i_sync_last_bit <= 1'b0;
		i_receive_data_full_flag <= 1'b1;
		@(posedge i_clk) i_sync_last_bit <= 1'b1;
		#1 chk("ovr none", f, 3'b000);
		@(posedge i_clk) i_sync_last_bit <= 1'b0;
		#1 chk("ovr", f, 3'b100);
		sw(1'b1, 3'b000);
		chk("ovr clr", f, 3'b000);
		$display("ovr done");
	endtask
	task automatic t_rst;
		@(posedge i_clk) i_sync_last_bit <= 1'b1;
		@(posedge i_clk) i_sync_last_bit <= 1'b0;
		#1 chk("rst pre", f, 3'b100);
		@(posedge i_clk) i_rst_n <= 1'b0;
		#1 chk("rst in", f, 3'b000);
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		#1 chk("rst out", f, 3'b000);
		$display("rst done");
	endtask
	initial begin
		{i_rst_n, i_master, i_transmit, i_flag_read, i_flag_write} = 5'h00;
		{i_receive_data_full_flag, i_sync_last_bit} = 2'h0;
		{i_wr_arb_lost_or_overrun, i_wr_own_address_match} = 2'h0;
		i_wr_general_call_match = 1'b0;
		{i_sda_drive, i_bus_format} = 2'h3;
		i_own_slave_address_field = 7'h2a;
		repeat (6) @(posedge i_clk);
		i_rst_n <= 1'b1;
		#1 chk("reset", f, 3'b000);
		t_own;
		t_gc;
		t_arb;
		t_ovr;
		t_rst;
		complete_run;
	end
	initial begin
		#300000;
		num_errors++;
		complete_run;
	end
endmodule
